// File: dram_ctrl_pkg.sv
package dram_ctrl_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W   = 9;
	localparam int BANK_W   = 2;
	localparam int NUM_BANK = 4;
	localparam int DIV_W    = 7;

	// ------------------------------------------------------------
	// refresh divisors and lengths
	// ------------------------------------------------------------
	localparam logic [DIV_W-1:0] DIV_61  = 7'h3D;
	localparam logic [DIV_W-1:0] DIV_91  = 7'h5B;
	localparam logic [DIV_W-1:0] DIV_106 = 7'h6A;
	localparam logic [DIV_W-1:0] DIV_121 = 7'h79;
	localparam logic [2:0] REF_LEN_3 = 3'h3;
	localparam logic [2:0] REF_LEN_4 = 3'h4;

	// ------------------------------------------------------------
	// access sequence timing, in clock cycles
	// ------------------------------------------------------------
	localparam logic [2:0] ROW_CYC  = 3'h1;
	localparam logic [2:0] COL_CYC  = 3'h2;
	localparam logic [2:0] WAIT_CYC = 3'h1;
	localparam logic [2:0] PRE_CYC  = 3'h1;
	localparam logic [2:0] ONE_CYC  = 3'h1;

	// ------------------------------------------------------------
	// controller states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE    = 6'b00_0001,
		ST_ROW     = 6'b00_0010,
		ST_COL     = 6'b00_0100,
		ST_WAIT    = 6'b00_1000,
		ST_PRECHG  = 6'b01_0000,
		ST_REFRESH = 6'b10_0000
	} ctrl_state_t;

endpackage : dram_ctrl_pkg

// File: refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none

module refresh_timer #(
	parameter int DIV_W = dram_ctrl_pkg::DIV_W
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             reset,
	// control
	input  wire logic             timerClear,
	input  wire logic [DIV_W-1:0] divisor,
	input  wire logic             tickTaken,
	// request
	output logic                  tickPending
);

	logic [DIV_W-1:0] count_reg;
	logic [DIV_W-1:0] count_next;
	logic             tickPending_next;
	wire              wrapHit = (count_reg == divisor - 1'b1);

	assign count_next       = (timerClear || wrapHit) ? '0 : count_reg + 1'b1;
	// set wins over take so a wrap never goes missing
	assign tickPending_next = timerClear ? 1'b0 : (wrapHit ? 1'b1 : (tickTaken ? 1'b0 : tickPending));

	always_ff @(posedge mclk) begin
		if (reset) begin
			count_reg   <= '0;
			tickPending <= 1'b0;
		end else begin
			count_reg   <= count_next;
			tickPending <= tickPending_next;
		end
	end

endmodule : refresh_timer

`default_nettype wire

// File: dram_refresh_access_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module dram_refresh_access_ctrl #(
	parameter int ADDR_W   = dram_ctrl_pkg::ADDR_W,
	parameter int NUM_BANK = dram_ctrl_pkg::NUM_BANK,
	parameter int BANK_W   = dram_ctrl_pkg::BANK_W
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              reset,
	// straps
	input  wire logic              wait_state_strap,
	input  wire logic              refresh_select_hi,
	input  wire logic              refresh_select_lo,
	// processor side
	input  wire logic              addrLatchStrobeN,
	input  wire logic              writeSel,
	input  wire logic [BANK_W-1:0] bankSel,
	input  wire logic [ADDR_W-1:0] row_addr_in,
	input  wire logic [ADDR_W-1:0] col_addr_in,
	input  wire logic              ext_refresh_request,
	// dram side
	output logic [ADDR_W-1:0]      dramAddr,
	output logic [NUM_BANK-1:0]    rowStrobeN,
	output logic [NUM_BANK-1:0]    colStrobeN,
	output logic                   writeStrobeN,
	// status
	output logic                   grantReady,
	output logic                   refreshActive,
	output logic                   accessGrantCycle
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// strap and control pins come from outside the clock domain; two stages each
	localparam int SYNC_N = 6;
	logic [SYNC_N-1:0] sync1_reg;
	logic [SYNC_N-1:0] sync2_reg;
	wire  [SYNC_N-1:0] rawIn = {wait_state_strap, refresh_select_hi, refresh_select_lo,
	                            addrLatchStrobeN, writeSel, ext_refresh_request};

	always_ff @(posedge mclk) begin
		if (reset) begin
			sync1_reg <= {SYNC_N{1'b1}};
			sync2_reg <= {SYNC_N{1'b1}};
		end else begin
			sync1_reg <= rawIn;
			sync2_reg <= sync1_reg;
		end
	end

	wire waitStrap  = sync2_reg[5];
	wire selHi      = sync2_reg[4];
	wire selLo      = sync2_reg[3];
	wire strobeN    = sync2_reg[2];
	wire writeReq   = sync2_reg[1];
	wire extRefReq  = sync2_reg[0];

	// ------------------------------------------------------------
	// strap decode
	// ------------------------------------------------------------
	wire externalMode = !waitStrap && !selHi;
	wire timerClear   = !waitStrap && !selHi && !selLo;
	wire [2:0] strapCode = {waitStrap, selHi, selLo};
	wire [dram_ctrl_pkg::DIV_W-1:0] divisor =
		(strapCode == 3'h2 || strapCode == 3'h4) ? dram_ctrl_pkg::DIV_61  :
		(strapCode == 3'h3 || strapCode == 3'h5) ? dram_ctrl_pkg::DIV_91  :
		(strapCode == 3'h6)                      ? dram_ctrl_pkg::DIV_106 :
		                                           dram_ctrl_pkg::DIV_121;
	// 91 at 8 MHz gives 11.375 us per row, 2.9 ms over 256 rows
	wire [2:0] refreshLen =
		(strapCode == 3'h1 || strapCode == 3'h2 || strapCode == 3'h4) ?
		dram_ctrl_pkg::REF_LEN_3 : dram_ctrl_pkg::REF_LEN_4;
	wire [2:0] waitLen = waitStrap ? dram_ctrl_pkg::WAIT_CYC : 3'h0;

	// ------------------------------------------------------------
	// refresh request sources
	// ------------------------------------------------------------
	logic tickPending;
	logic tickTaken;
	logic extRefPrev_reg;
	logic extPending_reg;
	logic extPending_next;

	refresh_timer #(
		.DIV_W      (dram_ctrl_pkg::DIV_W)
	) u_timer (
		.mclk       (mclk),
		.reset      (reset),
		.timerClear (timerClear),
		.divisor    (divisor),
		.tickTaken  (tickTaken),
		.tickPending(tickPending)
	);

	wire extRise    = extRefReq && !extRefPrev_reg;
	wire refreshDue = externalMode ? extPending_reg : tickPending;

	// ------------------------------------------------------------
	// access request capture
	// ------------------------------------------------------------
	logic strobePrev_reg;
	logic accPending_reg;
	logic accPending_next;
	logic accWrite_reg;
	logic [BANK_W-1:0] accBank_reg;
	logic [ADDR_W-1:0] rowLatch_reg;
	logic [ADDR_W-1:0] colLatch_reg;
	wire strobeFall = !strobeN && strobePrev_reg;

	// address pins are held by the host across the strobe; sampled
	// once the synchronised fall is seen
	always_ff @(posedge mclk) begin
		if (reset) begin
			rowLatch_reg <= '0;
			colLatch_reg <= '0;
			accBank_reg  <= '0;
			accWrite_reg <= 1'b0;
		end else if (strobeFall) begin
			rowLatch_reg <= row_addr_in;
			colLatch_reg <= col_addr_in;
			accBank_reg  <= bankSel;
			accWrite_reg <= writeReq;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	dram_ctrl_pkg::ctrl_state_t state_reg;
	dram_ctrl_pkg::ctrl_state_t state_next;
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic       afterRefresh_reg;
	logic       afterRefresh_next;
	logic       startAccess;
	logic       startRefresh;
	wire        cntDone = (cnt_reg == dram_ctrl_pkg::ONE_CYC);

	always_comb begin
		state_next   = state_reg;
		cnt_next     = cntDone ? cnt_reg : cnt_reg - 1'b1;
		startAccess  = 1'b0;
		startRefresh = 1'b0;
		case (state_reg)
			dram_ctrl_pkg::ST_IDLE: begin
				if (refreshDue) begin
					startRefresh = 1'b1;
					state_next   = dram_ctrl_pkg::ST_REFRESH;
					cnt_next     = refreshLen;
				end else if (accPending_reg) begin
					startAccess = 1'b1;
					state_next  = dram_ctrl_pkg::ST_ROW;
					cnt_next    = dram_ctrl_pkg::ROW_CYC;
				end
			end
			dram_ctrl_pkg::ST_ROW: begin
				state_next = dram_ctrl_pkg::ST_COL;
				cnt_next   = dram_ctrl_pkg::COL_CYC + waitLen;
			end
			dram_ctrl_pkg::ST_COL: begin
				if (cntDone) begin
					state_next = dram_ctrl_pkg::ST_WAIT;
				end
			end
			dram_ctrl_pkg::ST_WAIT: begin
				// row held until the host lifts its strobe
				if (strobeN) begin
					state_next = dram_ctrl_pkg::ST_PRECHG;
					cnt_next   = dram_ctrl_pkg::PRE_CYC;
				end
			end
			dram_ctrl_pkg::ST_PRECHG: begin
				if (cntDone) begin
					state_next = dram_ctrl_pkg::ST_IDLE;
				end
			end
			dram_ctrl_pkg::ST_REFRESH: begin
				if (cntDone) begin
					state_next = dram_ctrl_pkg::ST_PRECHG;
					cnt_next   = dram_ctrl_pkg::PRE_CYC;
				end
			end
			default: begin
				state_next = dram_ctrl_pkg::ST_IDLE;
			end
		endcase
	end

	assign tickTaken         = startRefresh && !externalMode;
	// new request wins over the take in the same cycle
	assign extPending_next   = extRise ? 1'b1 : ((startRefresh && externalMode) ? 1'b0 : extPending_reg);
	assign accPending_next   = strobeFall ? 1'b1 : (startAccess ? 1'b0 : accPending_reg);
	assign afterRefresh_next = startRefresh ? 1'b1 : (startAccess ? 1'b0 : afterRefresh_reg);

	// ------------------------------------------------------------
	// dram strobes, registered
	// ------------------------------------------------------------
	wire inRow    = (state_next == dram_ctrl_pkg::ST_ROW);
	wire inCol    = (state_next == dram_ctrl_pkg::ST_COL) || (state_next == dram_ctrl_pkg::ST_WAIT);
	wire inRef    = (state_next == dram_ctrl_pkg::ST_REFRESH);
	wire [NUM_BANK-1:0] bankHot = {{(NUM_BANK-1){1'b0}}, 1'b1} << accBank_reg;
	// refresh is row-only on all banks; column strobes stay off
	wire [NUM_BANK-1:0] rowStrobeN_next = inRef ? '0 : ((inRow || inCol) ? ~bankHot : '1);
	wire [NUM_BANK-1:0] colStrobeN_next = inCol ? ~bankHot : '1;
	// write strobe drops with row so it always leads the column strobe,
	// keeping dram outputs off for a shared data bus
	wire writeStrobeN_next = !((inRow || inCol) && accWrite_reg);
	wire [ADDR_W-1:0] dramAddr_next = inCol ? colLatch_reg : rowLatch_reg;
	wire grantReady_next = !(accPending_reg && (refreshDue || state_reg == dram_ctrl_pkg::ST_REFRESH
		|| afterRefresh_reg));

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg        <= dram_ctrl_pkg::ST_IDLE;
			cnt_reg          <= dram_ctrl_pkg::ONE_CYC;
			strobePrev_reg   <= 1'b1;
			extRefPrev_reg   <= 1'b1;
			extPending_reg   <= 1'b0;
			accPending_reg   <= 1'b0;
			afterRefresh_reg <= 1'b0;
			dramAddr         <= '0;
			rowStrobeN       <= '1;
			colStrobeN       <= '1;
			writeStrobeN     <= 1'b1;
			grantReady       <= 1'b1;
			refreshActive    <= 1'b0;
			accessGrantCycle <= 1'b0;
		end else begin
			state_reg        <= state_next;
			cnt_reg          <= cnt_next;
			strobePrev_reg   <= strobeN;
			extRefPrev_reg   <= extRefReq;
			extPending_reg   <= extPending_next;
			accPending_reg   <= accPending_next;
			afterRefresh_reg <= afterRefresh_next;
			dramAddr         <= dramAddr_next;
			rowStrobeN       <= rowStrobeN_next;
			colStrobeN       <= colStrobeN_next;
			writeStrobeN     <= writeStrobeN_next;
			grantReady       <= grantReady_next;
			refreshActive    <= inRef;
			accessGrantCycle <= startAccess ? afterRefresh_reg :
				((state_next == dram_ctrl_pkg::ST_IDLE) ? 1'b0 : accessGrantCycle);
		end
	end

endmodule : dram_refresh_access_ctrl

`default_nettype wire

// File: dram_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl_chk #(
	parameter int NUM_BANK = 4
) (
	input wire logic                mclk,
	input wire logic                reset,
	input wire logic                wait_state_strap,
	input wire logic                refresh_select_hi,
	input wire logic                refresh_select_lo,
	input wire logic [NUM_BANK-1:0] rowStrobeN,
	input wire logic [NUM_BANK-1:0] colStrobeN,
	input wire logic                writeStrobeN,
	input wire logic                grantReady,
	input wire logic                refreshActive,
	input wire logic                accessGrantCycle
);
	// ------------------------------------------------------------
	// refresh length counter
	// ------------------------------------------------------------
	logic [3:0] lowCnt_reg;
	wire        allLow = (rowStrobeN == '0);
	wire  [2:0] code   = {wait_state_strap, refresh_select_hi, refresh_select_lo};
	wire  [3:0] refLen = (code == 3'h1 || code == 3'h2 || code == 3'h4) ? 4'h3 : 4'h4;
	always_ff @(posedge mclk) begin
		lowCnt_reg <= (reset || !allLow) ? 4'h0 : lowCnt_reg + 4'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	chk_refresh_len: assert property ($fell(allLow) |-> lowCnt_reg == refLen)
		else $error("refresh length wrong");
	chk_write_early: assert property ((&$past(colStrobeN)) && !(&colStrobeN) && !writeStrobeN
		|-> !$past(writeStrobeN)) else $error("write strobe not before column");
	chk_col_after_row: assert property ((&$past(colStrobeN)) && !(&colStrobeN)
		|-> $past(rowStrobeN) != '1) else $error("column without row");
	chk_refresh_no_col: assert property (refreshActive |-> &colStrobeN)
		else $error("column strobe during refresh");
	chk_grant_wait: assert property ($fell(grantReady)
		|-> refreshActive || $past(refreshActive) || $past(refreshActive, 2))
		else $error("grant wait without refresh");
	chk_grant_after: assert property ($rose(accessGrantCycle) |-> $past(refreshActive, 2)
		|| $past(refreshActive, 3) || $past(refreshActive, 4))
		else $error("grant cycle not after refresh");
	chk_grant_row: assert property ($rose(accessGrantCycle)
		|-> ##[0:2] (rowStrobeN != '1 && rowStrobeN != '0)) else $error("grant cycle idle");
	chk_precharge: assert property ($rose(&rowStrobeN) |=> &rowStrobeN)
		else $error("precharge too short");
	cover property ($rose(refreshActive));
	cover property ($rose(accessGrantCycle));
	cover property (!writeStrobeN && colStrobeN != '1);
endmodule : dram_ctrl_chk
bind dram_refresh_access_ctrl dram_ctrl_chk #(.NUM_BANK(NUM_BANK)) dram_ctrl_chk_inst (.mclk,
	.reset, .wait_state_strap, .refresh_select_hi, .refresh_select_lo, .rowStrobeN,
	.colStrobeN, .writeStrobeN, .grantReady, .refreshActive, .accessGrantCycle);
`default_nettype wire

// File: dram_bank_model.sv
`timescale 1ns/1ps
`default_nettype none
module dram_bank_model (
	input wire logic       mclk,
	input wire logic [8:0] dramAddr,
	input wire logic [3:0] rowStrobeN,
	input wire logic [3:0] colStrobeN,
	input wire logic       writeStrobeN,
	output logic     [8:0] rowSeen,
	output logic     [8:0] colSeen,
	output logic     [3:0] bankSeen,
	output logic           earlyWrite
);
	// ------------------------------------------------------------
	// strobe edge capture
	// ------------------------------------------------------------
	logic [3:0] rowPrev = 4'hF;
	logic [3:0] colPrev = 4'hF;
	logic       wePrev  = 1'b1;
	always @(posedge mclk) begin
		// all rows low is a refresh, no address taken then
		if (rowPrev == 4'hF && rowStrobeN != 4'hF && rowStrobeN != 4'h0) rowSeen <= dramAddr;
		if (colPrev == 4'hF && colStrobeN != 4'hF) begin
			colSeen    <= dramAddr;
			bankSeen   <= ~colStrobeN;
			// early write only, so the host needs no output buffer
			earlyWrite <= !wePrev;
		end
		rowPrev <= rowStrobeN;
		colPrev <= colStrobeN;
		wePrev  <= writeStrobeN;
	end
endmodule : dram_bank_model
`default_nettype wire

// File: tb_dram_refresh_access_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dram_refresh_access_ctrl;
	logic mclk = 0, reset = 1, addrLatchStrobeN = 1, writeSel = 0, ext_refresh_request = 0;
	logic wait_state_strap = 0, refresh_select_hi = 0, refresh_select_lo = 0;
	logic [1:0] bankSel = '0;
	logic [8:0] row_addr_in = '0, col_addr_in = '0, dramAddr, rowSeen, colSeen;
	logic [3:0] rowStrobeN, colStrobeN, bankSeen;
	logic writeStrobeN, grantReady, refreshActive, accessGrantCycle, earlyWrite;
	logic sawWait = 0, sawGrant = 0;
	int fail_count = 0, checks = 0, cyc = 0, n;
	// bench clock stands for the already phase-shifted controller clock
	always #50 mclk = ~mclk;
	dram_refresh_access_ctrl dram_refresh_access_ctrl_inst (.mclk, .reset, .wait_state_strap,
		.refresh_select_hi, .refresh_select_lo, .addrLatchStrobeN, .writeSel, .bankSel,
		.row_addr_in, .col_addr_in, .ext_refresh_request, .dramAddr, .rowStrobeN, .colStrobeN,
		.writeStrobeN, .grantReady, .refreshActive, .accessGrantCycle);
	dram_bank_model dram_bank_model_inst (.mclk, .dramAddr, .rowStrobeN, .colStrobeN,
		.writeStrobeN, .rowSeen, .colSeen, .bankSeen, .earlyWrite);
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		// host acknowledge would be held off while this is low
		if (grantReady === 1'b0) sawWait <= 1;
		if (accessGrantCycle === 1'b1) sawGrant <= 1;
		cyc++;
		// hang guard, well above the whole sequence
		if (cyc == 20000) begin fail_count++; complete_run(); end
	end
	// inputs move 10 ns after the rising edge, far from the falling edge
	task automatic step(int k); repeat (k) @(posedge mclk); #10; endtask : step
	task automatic check_val(string what, logic [15:0] exp, logic [15:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check_val
	// straps only move under reset, so the synchronisers never see a change mid-run
	task automatic straps(logic [2:0] c);
		reset = 1; {wait_state_strap, refresh_select_hi, refresh_select_lo} = c;
		step(10); reset = 0; step(1);
	endtask : straps
	task automatic access(logic [1:0] b, logic w, logic [8:0] r, logic [8:0] c);
		bankSel = b; writeSel = w; row_addr_in = r; col_addr_in = c; addrLatchStrobeN = 0;
		n = 0;
		while (colStrobeN === 4'hF && n < 60) begin step(1); n++; end
		step(1);
		check_val("row", r, rowSeen);
		check_val("col", c, colSeen);
		check_val("bank", 4'h1 << b, bankSeen);
		check_val("early write", w, earlyWrite);
		addrLatchStrobeN = 1; step(8);
		check_val("idle", 4'hF, rowStrobeN);
	endtask : access
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_access;
		straps(3'h0); sawGrant = 0;
		for (int b = 0; b < 4; b++) begin
			access(b[1:0], 1'b1, 9'h1FF - b, 9'h100 + b);
			access(b[1:0], 1'b0, 9'h0 + b, 9'h0FF - b);
		end
		check_val("plain cycle", 0, sawGrant);
		straps(3'h7);
		access(2'h2, 1'b1, 9'h0AA, 9'h155);
		access(2'h1, 1'b0, 9'h155, 9'h0AA);
	endtask : test_access
	task automatic rate(logic [2:0] c, int div);
		straps(c); n = 0;
		while (refreshActive !== 1'b1 && n < 300) begin step(1); n++; end
		n = 0;
		while (refreshActive === 1'b1) begin step(1); n++; end
		while (refreshActive !== 1'b1 && n < 300) begin step(1); n++; end
		check_val("period", div, 16'(n));
		check_val("all rows in time", 1, n * 32000 < 4000000);
		if (c == 3'h3) check_val("row time at 8 MHz", 16'h2C6F, 16'(n * 125));
	endtask : rate
	task automatic test_rates;
		logic [2:0] codes [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
		int divs [6] = '{61, 91, 61, 91, 106, 121};
		foreach (codes[i]) rate(codes[i], divs[i]);
	endtask : test_rates
	task automatic test_ext(logic [2:0] c, int len);
		straps(c); ext_refresh_request = 1; n = 0;
		while (rowStrobeN !== 4'h0 && n < 20) begin step(1); n++; end
		ext_refresh_request = 0; n = 0;
		while (rowStrobeN === 4'h0) begin step(1); n++; end
		check_val("refresh length", len, 16'(n));
	endtask : test_ext
	task automatic test_hold;
		straps(3'h0); n = 0;
		repeat (300) begin step(1); if (refreshActive !== 1'b0) n++; end
		check_val("held timer", 0, 16'(n));
	endtask : test_hold
	task automatic test_grant;
		straps(3'h0); sawWait = 0; sawGrant = 0; ext_refresh_request = 1;
		access(2'h3, 1'b0, 9'h1A5, 9'h05A);
		ext_refresh_request = 0;
		check_val("grant wait", 1, sawWait);
		check_val("grant cycle", 1, sawGrant);
	endtask : test_grant
	task automatic complete_run;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	initial begin
		test_access;
		test_rates;
		test_ext(3'h0, 4);
		test_ext(3'h1, 3);
		test_hold;
		test_grant;
		complete_run;
	end
endmodule : tb_dram_refresh_access_ctrl
`default_nettype wire
